//--- logic/jpb_pkg.sv
package jpb_pkg;
    // register offsets on the 8-bit register port
    localparam logic [7:0] REG_STATE_VECTOR  = 8'hF8;
    localparam logic [7:0] REG_LINK_CTRL     = 8'hFA;
    localparam logic [7:0] REG_RT_DELAY      = 8'hFB;
    localparam logic [7:0] REG_PORT_CONTROL  = 8'hFD;
    localparam logic [7:0] REG_PORT_DATA     = 8'hFE;
    localparam logic [7:0] REG_PORT_DIR      = 8'hFF;
    // link port control field positions
    localparam int         CTL_PULLUP_BIT    = 0;
    localparam int         CTL_REDUCED_BIT   = 1;
    localparam int         CTL_ENABLE_BIT    = 2;
    // own link control field positions
    localparam int         LCT_IE_BIT        = 0;
    localparam int         LCT_TXGO_BIT      = 1;
    // shared pin positions
    localparam int         PIN_RX            = 0;
    localparam int         PIN_TX            = 1;
    // reset values
    localparam logic [7:0] PORT_CONTROL_RST  = 8'h00;
    localparam logic [6:0] PORT_DIR_RST      = 7'h00;
    localparam logic [6:0] PORT_DATA_RST     = 7'h00;
    localparam logic [3:0] RT_OFFSET_RST     = 4'h7;
    // state vector codes and the good CRC residue
    localparam logic [7:0] VEC_NONE          = 8'h00;
    localparam logic [7:0] VEC_CRC_ERROR     = 8'h18;
    localparam logic [7:0] VEC_SYMBOL_BAD    = 8'h1C;
    localparam logic [7:0] CRC_GOOD_RESIDUE  = 8'hC4;
    // round-trip delay timing
    localparam int         RT_BASE_US        = 9;
    localparam int         CLOCK_MHZ         = 100;
    localparam int         CYCLES_PER_US     = CLOCK_MHZ;
    localparam int         TX_ECHO_LAG       = 3;

    // events reported by the framing core on the same clock
    typedef struct packed {
        logic       txInvalid;   // own frame bad bit or misplaced framing
        logic       rxSymbolBad; // invalid symbol while receiving
        logic       rxFrameBad;  // EOD/EOF off a byte boundary
        logic       breakSeen;   // BREAK symbol on the bus
        logic       eodActive;   // sent EOD, saw an active symbol
        logic       crcDone;     // data and CRC byte processed
        logic [7:0] crcResidue;
        logic       sof;         // start of frame seen
        logic       busIdle;     // bus idle detected
        logic       txDone;      // frame sent fully
        logic       txBit;       // core wants the bus active
        logic       receiving;   // a frame is being received
    } jpb_evt_t;

    // register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } jpb_req_t;
endpackage

//--- logic/jpb_port_error.sv
//
// Contract
// - delay is 9 us plus offset value
// - enable clear: GPIO pins, controller off
// - enabled link functions override port functions
// - pull-up bit connects internal pull-ups
// - reduced-drive bit selects weak output drive
// - data read: pin if input, latch if output
// - data writes never disturb link output pin
// - reset leaves all pins high-impedance inputs
// - data bits 6..0, bit 7 reads zero
// - seven direction bits, set means output
// - own bad frame stops transmit, flags, interrupts
// - CRC residue not C4 sets CRC flag
// - invalid symbol flags, or lost arbitration transmitting
// - misaligned EOD/EOF flags symbol invalid
// - transmit starts only after bus passive
// - ground short aborts, idle until new command
// - fault gone means normal operation resumes
// - BREAK aborts transmit, is receive error
// - BREAK flags; vector read clears; await idle, SOF
// - controller never drives a BREAK
// - EOD then active symbol flags, await SOF
// - CRC error flags, discards until SOF
// - symbol invalid vector reads 1C
// - CRC error vector reads 18
// - offset sits in low four delay bits
module jpb_port_error
    import jpb_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire jpb_req_t    req,
    output logic      [7:0]  rdata,
    input  wire jpb_evt_t    evt,
    input  wire logic [6:0]  pinIn,
    output logic      [6:0]  pinOut,
    output logic      [6:0]  pinOe,
    output logic             pullupEn,
    output logic             reducedDrive,
    output logic             linkActive,
    output logic             txRun,
    output logic             txAbort,
    output logic             lostArb,
    output logic             rxDiscard,
    output logic             irq,
    output logic      [11:0] rtDelayCycles
);

    typedef enum logic [1:0] {TX_IDLE, TX_WAIT, TX_RUN} jpb_tx_t;
    typedef enum logic [1:0] {RX_NORMAL, RX_WAIT_IDLE, RX_WAIT_SOF} jpb_rx_t;

    // expected delay in clock cycles for an offset value
    function automatic logic [11:0] delayCycles(input logic [3:0] off);
        delayCycles = 12'((RT_BASE_US + int'(off)) * CYCLES_PER_US);
    endfunction

    logic [7:0] portCtl_r;
    logic [6:0] portData_r;
    logic [6:0] portDir_r;
    logic [3:0] rtOffset_r;
    logic       ie_r;
    logic [6:0] pinMeta_r;
    logic [6:0] pinSync_r;
    logic       symBad_r;
    logic       crcBad_r;
    logic [TX_ECHO_LAG-1:0] txEcho_r;
    jpb_tx_t    txState_r;
    jpb_rx_t    rxState_r;
    logic       txAbort_r;
    logic       lostArb_r;
    logic [7:0] rdata_r;

    logic       enabled;
    logic       busActive;
    logic       wrHit;
    logic       vecRead;
    logic [7:0] vector;
    logic       groundShort;
    logic       txErr;
    logic       txSymLost;
    logic       crcFail;
    logic       setSym;
    logic [6:0] portRead;

    assign enabled   = portCtl_r[CTL_ENABLE_BIT];
    assign busActive = pinSync_r[PIN_RX]; // synchronised receive pin only
    assign wrHit     = req.wr;
    assign vecRead   = req.rd && (req.addr == REG_STATE_VECTOR);

    ////////////////////////////////////////////////////////////////////
    // pin synchroniser, second stage is the only reader of the first
    always_ff @(posedge clock) begin
        if (srst) begin
            pinMeta_r <= 7'h00;
            pinSync_r <= 7'h00;
        end else begin
            pinMeta_r <= pinIn;
            pinSync_r <= pinMeta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge clock) begin
        if (srst) begin
            portCtl_r  <= PORT_CONTROL_RST;
            portData_r <= PORT_DATA_RST;
            portDir_r  <= PORT_DIR_RST;
            rtOffset_r <= RT_OFFSET_RST;
            ie_r       <= 1'b0;
        end else if (wrHit) begin
            case (req.addr)
                REG_PORT_CONTROL: portCtl_r  <= {5'h00, req.wdata[2:0]};
                REG_PORT_DATA:    portData_r <= req.wdata[6:0];
                REG_PORT_DIR:     portDir_r  <= req.wdata[6:0];
                REG_RT_DELAY:     rtOffset_r <= req.wdata[3:0];
                REG_LINK_CTRL:    ie_r       <= req.wdata[LCT_IE_BIT];
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin muxing; link owns tx and rx pins while enabled
    always_comb begin
        pinOut = portData_r;
        pinOe  = portDir_r;
        if (enabled) begin
            pinOut[PIN_TX] = evt.txBit && (txState_r == TX_RUN);
            pinOe[PIN_TX]  = 1'b1;
            pinOut[PIN_RX] = 1'b0;
            pinOe[PIN_RX]  = 1'b0;
        end
    end

    assign pullupEn     = portCtl_r[CTL_PULLUP_BIT];
    assign reducedDrive = portCtl_r[CTL_REDUCED_BIT];
    assign linkActive   = enabled;

    // pin level for inputs, latch for outputs
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            portRead[i] = pinOe[i] ? portData_r[i] : pinSync_r[i];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // error detection
    // echo lag covers pin drive out plus the two-flop return path
    always_ff @(posedge clock) begin
        if (srst) begin
            txEcho_r <= '0;
        end else begin
            txEcho_r <= {txEcho_r[TX_ECHO_LAG-2:0], pinOut[PIN_TX] && enabled};
        end
    end

    assign groundShort = (txState_r == TX_RUN) && txEcho_r[TX_ECHO_LAG-1] && !busActive;
    assign txErr       = (txState_r == TX_RUN) && (evt.txInvalid || evt.breakSeen || groundShort);
    // a bad symbol while sending is taken as lost arbitration
    assign txSymLost   = (txState_r == TX_RUN) && evt.rxSymbolBad;
    assign crcFail     = enabled && evt.crcDone && (evt.crcResidue != CRC_GOOD_RESIDUE);
    assign setSym      = enabled && (txErr || (evt.rxSymbolBad && !txSymLost) || evt.rxFrameBad
                         || evt.breakSeen || evt.eodActive);

    ////////////////////////////////////////////////////////////////////
    // sticky flags; a new event wins over the clearing read
    always_ff @(posedge clock) begin
        if (srst || !enabled) begin
            symBad_r <= 1'b0;
        end else if (setSym) begin
            symBad_r <= 1'b1;
        end else if (vecRead && symBad_r) begin
            symBad_r <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (srst || !enabled) begin
            crcBad_r <= 1'b0;
        end else if (crcFail) begin
            crcBad_r <= 1'b1;
        end else if (vecRead && !symBad_r) begin
            crcBad_r <= 1'b0; // only the reported source clears
        end
    end

    // highest pending source wins the vector
    always_comb begin
        if (symBad_r) begin
            vector = VEC_SYMBOL_BAD;
        end else if (crcBad_r) begin
            vector = VEC_CRC_ERROR;
        end else begin
            vector = VEC_NONE;
        end
    end

    assign irq = ie_r && (symBad_r || crcBad_r);

    ////////////////////////////////////////////////////////////////////
    // transmit control
    always_ff @(posedge clock) begin
        if (srst || !enabled) begin
            txState_r <= TX_IDLE;
            txAbort_r <= 1'b0;
            lostArb_r <= 1'b0;
        end else begin
            txAbort_r <= 1'b0;
            lostArb_r <= 1'b0;
            case (txState_r)
                TX_IDLE: begin
                    if (wrHit && req.addr == REG_LINK_CTRL && req.wdata[LCT_TXGO_BIT]) begin
                        txState_r <= TX_WAIT;
                    end
                end
                TX_WAIT: begin
                    // shorted-high bus keeps us here until released
                    if (!busActive) begin
                        txState_r <= TX_RUN;
                    end
                end
                TX_RUN: begin
                    if (txErr) begin
                        txState_r <= TX_IDLE;
                        txAbort_r <= 1'b1;
                    end else if (txSymLost) begin
                        txState_r <= TX_IDLE;
                        lostArb_r <= 1'b1;
                    end else if (evt.txDone) begin
                        txState_r <= TX_IDLE;
                    end
                end
                default: txState_r <= TX_IDLE;
            endcase
        end
    end

    assign txRun   = (txState_r == TX_RUN);
    assign txAbort = txAbort_r;
    assign lostArb = lostArb_r;

    ////////////////////////////////////////////////////////////////////
    // receive recovery after errors
    always_ff @(posedge clock) begin
        if (srst || !enabled) begin
            rxState_r <= RX_NORMAL;
        end else begin
            case (rxState_r)
                RX_NORMAL: begin
                    if (evt.breakSeen && (evt.receiving || txState_r == TX_RUN)) begin
                        rxState_r <= RX_WAIT_IDLE;
                    end else if (crcFail || evt.rxFrameBad || evt.eodActive) begin
                        rxState_r <= RX_WAIT_SOF;
                    end
                end
                RX_WAIT_IDLE: if (evt.busIdle) begin
                    rxState_r <= RX_WAIT_SOF;
                end
                RX_WAIT_SOF: if (evt.sof) begin
                    rxState_r <= RX_NORMAL;
                end
                default: rxState_r <= RX_NORMAL;
            endcase
        end
    end

    assign rxDiscard = (rxState_r != RX_NORMAL);

    ////////////////////////////////////////////////////////////////////
    // read port, data one cycle after the strobe
    always_ff @(posedge clock) begin
        if (srst) begin
            rdata_r       <= 8'h00;
            rtDelayCycles <= delayCycles(RT_OFFSET_RST);
        end else begin
            rtDelayCycles <= delayCycles(rtOffset_r);
            if (req.rd) begin
                case (req.addr)
                    REG_STATE_VECTOR: rdata_r <= vector;
                    REG_LINK_CTRL:    rdata_r <= {4'h0, rxDiscard, txRun, 1'b0, ie_r};
                    REG_RT_DELAY:     rdata_r <= {4'h0, rtOffset_r};
                    REG_PORT_CONTROL: rdata_r <= portCtl_r;
                    REG_PORT_DATA:    rdata_r <= {1'b0, portRead};
                    REG_PORT_DIR:     rdata_r <= {1'b0, portDir_r};
                    default:          rdata_r <= 8'h00;
                endcase
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_crc_flag_set: assert property (crcFail |=> crcBad_r)
        else $error("crc residue mismatch did not set flag");
    a_sym_vector: assert property (symBad_r && req.rd && req.addr == REG_STATE_VECTOR
        |=> rdata == VEC_SYMBOL_BAD)
        else $error("symbol vector not 1C");
    a_crc_vector: assert property (!symBad_r && crcBad_r && req.rd && req.addr == REG_STATE_VECTOR
        |=> rdata == VEC_CRC_ERROR)
        else $error("crc vector not 18");
    a_tx_abort_err: assert property (txRun && evt.txInvalid |=> !txRun && txAbort)
        else $error("transmit not stopped on error");
    a_wait_passive: assert property (txState_r == TX_WAIT && busActive |=> !txRun)
        else $error("transmit began on active bus");
    a_gpio_off: assert property (!enabled |-> pinOe == portDir_r && pinOut == portData_r)
        else $error("pins not general purpose while off");
    a_tx_pin_own: assert property (enabled |-> pinOe[PIN_TX] && !pinOe[PIN_RX])
        else $error("link pins not overriding port");
    a_bit7_zero: assert property (req.rd && req.addr == REG_PORT_DATA |=> rdata[7] == 1'b0)
        else $error("data bit 7 not zero");
    a_break_recover: assert property (enabled && rxState_r == RX_NORMAL && evt.breakSeen && evt.receiving
        |=> rxState_r == RX_WAIT_IDLE ##0 symBad_r)
        else $error("break not handled");
    a_delay_map: assert property (##1 rtDelayCycles == delayCycles($past(rtOffset_r)))
        else $error("delay cycles wrong");
    // error reactions while sending and receiving, transmit pin quiet outside a frame
    a_short_abort: assert property (groundShort |=> txAbort && !txRun)
        else $error("ground short did not abort transmit");
    a_lost_arb: assert property (txSymLost && !txErr |=> lostArb && !txRun)
        else $error("bad symbol while sending not lost arbitration");
    a_crc_discard: assert property (crcFail |=> rxDiscard)
        else $error("crc error did not start discard");
    a_tx_quiet: assert property (enabled && !txRun |-> !pinOut[PIN_TX])
        else $error("transmit pin active outside a frame");

    c_ground_short: cover property (groundShort ##1 txAbort);
    c_crc_discard:  cover property (crcFail ##1 rxDiscard ##[1:20] !rxDiscard);
    c_vec_clear:    cover property (symBad_r && vecRead ##1 !symBad_r);
    c_lost_arb:     cover property (txSymLost ##1 lostArb);

endmodule // jpb_port_error

//--- verification/jpb_xcvr_model.sv
// bus transceiver on the shared pins; the passive bus sits low
module jpb_xcvr_model #(
    parameter int LAG = 1
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic txDrive,
    input  wire logic shortBatt,
    input  wire logic shortGnd,
    output logic      rxLevel
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] echo_r;

    // echo of our own drive, LAG cycles late; larger LAG models a slow part
    always_ff @(posedge clock) begin
        if (srst) begin
            echo_r <= 8'h00;
        end else begin
            echo_r <= {echo_r[6:0], txDrive};
        end
    end

    // a short wins over any drive, so it shows at the receive pin
    assign rxLevel = shortBatt ? 1'b1 : (shortGnd ? 1'b0 : echo_r[LAG-1]);
endmodule // jpb_xcvr_model

//--- verification/jpb_port_error_tb.sv
module jpb_port_error_tb
    import jpb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, srst, shortBatt, shortGnd, rxLevel;
    logic        pullupEn, reducedDrive, linkActive, txRun, txAbort, lostArb, rxDiscard, irq, seen;
    jpb_req_t    req;
    jpb_evt_t    evt, evtBase, e;
    logic [7:0]  rdata;
    logic [6:0]  pinIn, pinOut, pinOe;
    logic [5:0]  gpioIn;
    logic [11:0] rtDelayCycles;
    int          err_count, n_compared, i, k;

    jpb_port_error dut (.clock(clock), .srst(srst), .req(req), .rdata(rdata), .evt(evt), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pullupEn(pullupEn), .reducedDrive(reducedDrive),
        .linkActive(linkActive), .txRun(txRun), .txAbort(txAbort), .lostArb(lostArb),
        .rxDiscard(rxDiscard), .irq(irq), .rtDelayCycles(rtDelayCycles));
    jpb_xcvr_model xcvr (.clock(clock), .srst(srst), .txDrive(pinOe[PIN_TX] & pinOut[PIN_TX]), .shortBatt(shortBatt),
        .shortGnd(shortGnd), .rxLevel(rxLevel));

    // wire level: a driven pin reads back its own drive
    assign pinIn = (pinOe & pinOut) | (~pinOe & {gpioIn, rxLevel});

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clock);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask

    task automatic pulse(input jpb_evt_t x);
        @(posedge clock);
        evt <= evtBase | x;
        @(posedge clock);
        evt <= evtBase;
    endtask

    task automatic tick();
        @(posedge clock);
        #1;
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        #1 chk("pinOe", pinOe, 16'h0);
        rd(REG_PORT_CONTROL, 8'h00, "control");
        rd(REG_PORT_DIR, 8'h00, "direction");
        rd(REG_PORT_DATA, 8'h00, "data");
        rd(REG_STATE_VECTOR, VEC_NONE, "vector");
        rd(REG_RT_DELAY, 8'h07, "offset");
        chk("delay", rtDelayCycles, 16'h0640);
    endtask

    // every offset code, both ends included
    task automatic t_delay();
        for (i = 0; i < 16; i++) begin
            wr(REG_RT_DELAY, 8'(i));
            repeat (2) tick();
            chk("delay", rtDelayCycles, 16'((9 + i) * 100));
        end
    endtask

    task automatic t_port();
        wr(REG_PORT_DIR, 8'h7F);
        wr(REG_PORT_DATA, 8'h55);
        tick();
        chk("pinOe", pinOe, 16'h7F);
        chk("pinOut", pinOut, 16'h55);
        rd(REG_PORT_DATA, 8'h55, "data");
        wr(REG_PORT_DATA, 8'hFF);
        rd(REG_PORT_DATA, 8'h7F, "data");
        wr(REG_PORT_DIR, 8'h00);
        gpioIn <= 6'h2A;
        repeat (3) tick();
        rd(REG_PORT_DATA, 8'h54, "pins");
        chk("pinOe", pinOe, 16'h0);
    endtask

    // only the three low bits of control exist
    task automatic t_control();
        wr(REG_PORT_CONTROL, 8'hFF);
        tick();
        chk("pullupEn", pullupEn, 16'h1);
        chk("reducedDrive", reducedDrive, 16'h1);
        chk("linkActive", linkActive, 16'h1);
        rd(REG_PORT_CONTROL, 8'h07, "control");
        wr(REG_PORT_CONTROL, 8'h00);
        tick();
        chk("pullupEn", pullupEn, 16'h0);
        chk("reducedDrive", reducedDrive, 16'h0);
    endtask

    // idle link keeps its transmit pin passive whatever the latch holds
    task automatic t_override();
        wr(REG_PORT_CONTROL, 8'h04);
        wr(REG_PORT_DIR, 8'h03);
        wr(REG_PORT_DATA, 8'h00);
        tick();
        chk("pinOut tx", pinOut[PIN_TX], 16'h0);
        wr(REG_PORT_DATA, 8'h02);
        tick();
        chk("pinOut tx", pinOut[PIN_TX], 16'h0);
        wr(REG_PORT_DIR, 8'h00);
    endtask

    task automatic t_crc();
        e = '0;
        e.crcDone = 1'b1;
        e.crcResidue = CRC_GOOD_RESIDUE;
        pulse(e);
        rd(REG_STATE_VECTOR, VEC_NONE, "vector");
        e.crcResidue = 8'h3B;
        pulse(e);
        wr(REG_LINK_CTRL, 8'h01);
        tick();
        chk("irq", irq, 16'h1);
        chk("rxDiscard", rxDiscard, 16'h1);
        rd(REG_STATE_VECTOR, VEC_CRC_ERROR, "vector");
        chk("irq", irq, 16'h0);
        e = '0;
        e.sof = 1'b1;
        pulse(e);
        tick();
        chk("rxDiscard", rxDiscard, 16'h0);
    endtask

    // the four symbol faults seen while receiving
    task automatic t_symbol();
        evtBase.receiving = 1'b1;
        for (k = 0; k < 4; k++) begin
            e = '0;
            e.rxSymbolBad = (k == 0);
            e.rxFrameBad = (k == 1);
            e.breakSeen = (k == 2);
            e.eodActive = (k == 3);
            pulse(e);
            rd(REG_STATE_VECTOR, VEC_SYMBOL_BAD, "vector");
            rd(REG_STATE_VECTOR, VEC_NONE, "vector");
            if (k > 0) chk("rxDiscard", rxDiscard, 16'h1);
            e = '0;
            e.busIdle = 1'b1;
            pulse(e);
            e = '0;
            e.sof = 1'b1;
            pulse(e);
            tick();
            chk("rxDiscard", rxDiscard, 16'h0);
        end
        evtBase.receiving = 1'b0;
    endtask

    task automatic t_transmit();
        shortBatt <= 1'b1;
        wr(REG_LINK_CTRL, 8'h03);
        repeat (10) tick();
        chk("txRun", txRun, 16'h0);
        shortBatt <= 1'b0;
        for (i = 0; i < 20 && txRun !== 1'b1; i++) tick();
        chk("txRun", txRun, 16'h1);
        evtBase.txBit = 1'b1;
        shortGnd <= 1'b1;
        pulse('0);
        for (i = 0; i < 20 && txAbort !== 1'b1; i++) tick();
        chk("txAbort", txAbort, 16'h1);
        tick();
        chk("txRun", txRun, 16'h0);
        chk("irq", irq, 16'h1);
        rd(REG_STATE_VECTOR, VEC_SYMBOL_BAD, "vector");
        evtBase.txBit = 1'b0;
        shortGnd <= 1'b0;
        pulse('0);
        repeat (10) tick();
        chk("txRun", txRun, 16'h0);
        wr(REG_LINK_CTRL, 8'h03);
        for (i = 0; i < 20 && txRun !== 1'b1; i++) tick();
        chk("txRun", txRun, 16'h1);
        evtBase.txBit = 1'b1;
        pulse('0);
        seen = 1'b0;
        repeat (8) begin
            tick();
            seen |= (txAbort === 1'b1);
        end
        chk("txAbort", seen, 16'h0);
        chk("pinOut tx", pinOut[PIN_TX], 16'h1);
        e = '0;
        e.rxSymbolBad = 1'b1;
        pulse(e);
        #1 seen = 1'b0;
        repeat (3) begin
            seen |= (lostArb === 1'b1);
            tick();
        end
        chk("lostArb", seen, 16'h1);
        evtBase.txBit = 1'b0;
        e = '0;
        e.txDone = 1'b1;
        pulse(e);
    endtask

    // own bad frame, then a BREAK, each while sending
    task automatic t_tx_errors();
        for (k = 0; k < 2; k++) begin
            wr(REG_LINK_CTRL, 8'h03);
            for (i = 0; i < 20 && txRun !== 1'b1; i++) tick();
            rd(REG_LINK_CTRL, 8'h05, "link control");
            e = '0;
            e.txInvalid = (k == 0);
            e.breakSeen = (k == 1);
            pulse(e);
            #1 chk("txAbort", txAbort, 16'h1);
            chk("txRun", txRun, 16'h0);
            chk("rxDiscard", rxDiscard, 16'(k));
            rd(REG_STATE_VECTOR, VEC_SYMBOL_BAD, "vector");
            e = '0;
            e.busIdle = 1'b1;
            pulse(e);
            e = '0;
            e.sof = 1'b1;
            pulse(e);
        end
    endtask

    // a disabled link ignores a CRC error and a BREAK
    task automatic t_disabled();
        wr(REG_PORT_CONTROL, 8'h00);
        e = '0;
        e.crcDone = 1'b1;
        e.breakSeen = 1'b1;
        pulse(e);
        rd(REG_STATE_VECTOR, VEC_NONE, "vector");
        chk("linkActive", linkActive, 16'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        err_count = 0;
        n_compared = 0;
        srst = 1'b1;
        req = '0;
        evt = '0;
        evtBase = '0;
        gpioIn = '0;
        shortBatt = 1'b0;
        shortGnd = 1'b0;
        repeat (5) @(posedge clock);
        srst <= 1'b0;
        t_reset();
        t_delay();
        t_port();
        t_control();
        t_override();
        t_crc();
        t_symbol();
        t_transmit();
        t_tx_errors();
        t_disabled();
        give_verdict();
    end

    // the whole run needs well under a thousand cycles
    initial begin
        #100000;
        err_count++;
        give_verdict();
    end
endmodule // jpb_port_error_tb
